/* rtl/smsc_cmd.sv */
// questionable status mask and serial / bus port settings, command and query side
`timescale 1ns/1ps
`include "smsc_defs.svh"

module smsc_cmd
#(
    parameter int ADDR_W = 5,
    parameter int DIV_W  = 13
)
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // parsed command in, answer out
    input  wire logic                   cmd_valid,
    input  wire smsc_pkg::smsc_cmd_t    cmd_code,
    input  wire logic [15:0]            cmd_arg,
    output logic                        resp_valid,
    output logic      [15:0]            resp_data,
    output logic                        cmd_reject,
    // questionable status
    input  wire logic [15:0]            ques_cond,
    input  wire logic [7:0]             status_byte_in,
    output logic      [7:0]             status_byte,
    // parallel bus addressing
    input  wire logic [ADDR_W-1:0]      bus_target_addr,
    output logic                        addr_match,
    output logic      [ADDR_W-1:0]      bus_addr,
    // serial port
    output logic      [DIV_W-1:0]       baud_div,
    input  wire logic                   parse_done,
    input  wire logic                   rx_valid,
    input  wire logic [7:0]             rx_char,
    output logic                        tx_valid,
    output logic      [7:0]             tx_char,
    input  wire logic                   tx_ready,
    output logic                        tx_paused
);
    import smsc_pkg::*;

    localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(`SMSC_DIV_19200);
    localparam logic [DIV_W-1:0] DIV_9600  = DIV_W'(`SMSC_DIV_9600);
    localparam logic [DIV_W-1:0] DIV_4800  = DIV_W'(`SMSC_DIV_4800);
    localparam logic [DIV_W-1:0] DIV_2400  = DIV_W'(`SMSC_DIV_2400);

    logic [15:0]       qmask_reg,   qmask_next;
    logic [15:0]       qevent_reg,  qevent_next;
    logic [ADDR_W-1:0] addr_reg,    addr_next;
    smsc_baud_t        baud_reg,    baud_next;
    logic              pace_reg,    pace_next;
    logic              prom_reg,    prom_next;
    logic              rvalid_reg,  rvalid_next;
    logic [15:0]       rdata_reg,   rdata_next;
    logic              rej_reg,     rej_next;
    logic [DIV_W-1:0]  div_reg,     div_next;
    logic              echo_on_req;
    logic              echo_off_req;
    logic              echo_active;
    logic [15:0]       latch_set;
    logic              ques_sum;
    logic              do_cmd;

    assign do_cmd = cmd_valid;

    // latching: only the two error bits ever enter the event register
    always_comb
    begin
        latch_set = 16'h0000;
        latch_set[`SMSC_CE_BIT] = ques_cond[`SMSC_CE_BIT];
        latch_set[`SMSC_VE_BIT] = ques_cond[`SMSC_VE_BIT];
    end

    assign ques_sum = |(qevent_reg & qmask_reg);

    always_comb
    begin
        status_byte = status_byte_in;
        status_byte[`SMSC_SB_QUES_BIT] = ques_sum;
    end

    // mask and event register
    always_comb
    begin
        qmask_next  = qmask_reg;
        qevent_next = qevent_reg;
        if (do_cmd && cmd_code == SMSC_CMD_QMASK_SET)
            qmask_next = cmd_arg;
        if (do_cmd && cmd_code == SMSC_CMD_QEVENT_QRY)
            qevent_next = 16'h0000;
        // a new event in the clearing cycle is kept
        qevent_next = qevent_next | latch_set;
    end

    // port settings
    always_comb
    begin
        addr_next    = addr_reg;
        baud_next    = baud_reg;
        pace_next    = pace_reg;
        prom_next    = prom_reg;
        rej_next     = 1'b0;
        echo_on_req  = 1'b0;
        echo_off_req = 1'b0;
        if (do_cmd)
        begin
            unique case (cmd_code)
                SMSC_CMD_ADDR_SET:
                begin
                    if (cmd_arg <= 16'(`SMSC_ADDR_MAX))
                        addr_next = cmd_arg[ADDR_W-1:0];
                    else
                        rej_next = 1'b1;
                end
                SMSC_CMD_BAUD_SET:
                begin
                    unique case (cmd_arg)
                        `SMSC_BAUD_19200: baud_next = SMSC_B19200;
                        `SMSC_BAUD_9600:  baud_next = SMSC_B9600;
                        `SMSC_BAUD_4800:  baud_next = SMSC_B4800;
                        `SMSC_BAUD_2400:  baud_next = SMSC_B2400;
                        default:          rej_next  = 1'b1;
                    endcase
                end
                SMSC_CMD_ECHO_SET:
                begin
                    if (cmd_arg == `SMSC_ANS_ON)
                        echo_on_req = 1'b1;
                    else if (cmd_arg == `SMSC_ANS_OFF)
                        echo_off_req = 1'b1;
                    else
                        rej_next = 1'b1;
                end
                SMSC_CMD_PACE_SET:
                begin
                    if (cmd_arg == `SMSC_ANS_ON || cmd_arg == `SMSC_ANS_OFF)
                        pace_next = cmd_arg[0];
                    else
                        rej_next = 1'b1;
                end
                SMSC_CMD_PROM_SET:
                begin
                    if (cmd_arg == `SMSC_ANS_ON || cmd_arg == `SMSC_ANS_OFF)
                        prom_next = cmd_arg[0];
                    else
                        rej_next = 1'b1;
                end
                SMSC_CMD_DEV_RESET:
                begin
                    // echo is left as it is
                    pace_next = 1'b0;
                    prom_next = 1'b0;
                end
                default:
                begin
                    rej_next = (cmd_code == SMSC_CMD_NONE);
                end
            endcase
        end
    end

    // divider for the serial bit clock
    always_comb
    begin
        unique case (baud_next)
            SMSC_B19200: div_next = DIV_19200;
            SMSC_B9600:  div_next = DIV_9600;
            SMSC_B4800:  div_next = DIV_4800;
            SMSC_B2400:  div_next = DIV_2400;
            default:     div_next = DIV_9600;
        endcase
    end

    // query answers
    always_comb
    begin
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        if (do_cmd)
        begin
            rvalid_next = 1'b1;
            unique case (cmd_code)
                SMSC_CMD_QMASK_QRY:  rdata_next = qmask_reg;
                SMSC_CMD_QEVENT_QRY: rdata_next = qevent_reg;
                SMSC_CMD_ADDR_QRY:   rdata_next = 16'(addr_reg);
                SMSC_CMD_BAUD_QRY:
                begin
                    unique case (baud_reg)
                        SMSC_B19200: rdata_next = `SMSC_BAUD_19200;
                        SMSC_B9600:  rdata_next = `SMSC_BAUD_9600;
                        SMSC_B4800:  rdata_next = `SMSC_BAUD_4800;
                        SMSC_B2400:  rdata_next = `SMSC_BAUD_2400;
                        default:     rdata_next = `SMSC_BAUD_9600;
                    endcase
                end
                SMSC_CMD_ECHO_QRY:
                    rdata_next = echo_active ? `SMSC_ANS_ON : `SMSC_ANS_OFF;
                SMSC_CMD_PACE_QRY:
                    rdata_next = pace_reg ? `SMSC_ANS_ON : `SMSC_ANS_OFF;
                SMSC_CMD_PROM_QRY:
                    rdata_next = prom_reg ? `SMSC_ANS_ON : `SMSC_ANS_OFF;
                default:
                    rvalid_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            qmask_reg  <= `SMSC_QMASK_RST;
            qevent_reg <= 16'h0000;
            addr_reg   <= ADDR_W'(`SMSC_ADDR_RST);
            baud_reg   <= SMSC_B9600;
            pace_reg   <= 1'b0;
            prom_reg   <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 16'h0000;
            rej_reg    <= 1'b0;
            div_reg    <= DIV_9600;
        end
        else
        begin
            qmask_reg  <= qmask_next;
            qevent_reg <= qevent_next;
            addr_reg   <= addr_next;
            baud_reg   <= baud_next;
            pace_reg   <= pace_next;
            prom_reg   <= prom_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rej_reg    <= rej_next;
            div_reg    <= div_next;
        end
    end

    assign resp_valid = rvalid_reg;
    assign resp_data  = rdata_reg;
    assign cmd_reject = rej_reg;
    assign bus_addr   = addr_reg;
    assign addr_match = (bus_target_addr == addr_reg);
    assign baud_div   = div_reg;

    smsc_ser_echo u_ser
    (
        .core_clk     (core_clk),
        .reset        (reset),
        .echo_on_req  (echo_on_req),
        .echo_off_req (echo_off_req),
        .pace_en      (pace_reg),
        .prompt_en    (prom_reg),
        .parse_done   (parse_done),
        .rx_valid     (rx_valid),
        .rx_char      (rx_char),
        .tx_valid     (tx_valid),
        .tx_char      (tx_char),
        .tx_ready     (tx_ready),
        .echo_active  (echo_active),
        .tx_paused    (tx_paused)
    );

    chk_summary_bit: assert property (@(posedge core_clk) disable iff (reset)
        status_byte[`SMSC_SB_QUES_BIT] == |(qevent_reg & qmask_reg))
        else $error("summary bit wrong");

    chk_mask_write: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_QMASK_SET) |=> qmask_reg == $past(cmd_arg))
        else $error("mask not stored");

    chk_mask_query: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_QMASK_QRY) |=>
            (resp_valid && resp_data == qmask_reg && $stable(qmask_reg)))
        else $error("mask query wrong");

    chk_addr_range: assert property (@(posedge core_clk) disable iff (reset)
        addr_reg <= `SMSC_ADDR_MAX)
        else $error("address out of range");

    chk_addr_reject: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_ADDR_SET && cmd_arg > 16'(`SMSC_ADDR_MAX)) |=>
            (cmd_reject && $stable(addr_reg)))
        else $error("bad address accepted");

    chk_event_clear: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_QEVENT_QRY) |=>
            (resp_data == $past(qevent_reg) && qevent_reg == $past(latch_set)))
        else $error("event read did not clear");

    chk_event_bits: assert property (@(posedge core_clk) disable iff (reset)
        (qevent_reg & 16'hcfff) == 16'h0000)
        else $error("unlatched bit set");

    chk_reset_echo: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_DEV_RESET) |=> $stable(echo_active))
        else $error("reset changed echo");

    chk_baud_div: assert property (@(posedge core_clk) disable iff (reset)
        (cmd_valid && cmd_code == SMSC_CMD_BAUD_SET && cmd_arg == `SMSC_BAUD_2400) |=>
            baud_div == DIV_2400)
        else $error("baud divider wrong");

endmodule

/* rtl/smsc_defs.svh */
// field positions, codes, reset values and timing constants of the status and serial block
`ifndef SMSC_DEFS_SVH
`define SMSC_DEFS_SVH

`define SMSC_CLK_HZ          10000000
`define SMSC_CE_BIT          13
`define SMSC_VE_BIT          12
`define SMSC_SB_QUES_BIT     3
`define SMSC_ADDR_MAX        5'h1e
`define SMSC_ADDR_RST        5'h06
`define SMSC_QMASK_RST       16'h0000
`define SMSC_BAUD_19200      16'h4b00
`define SMSC_BAUD_9600       16'h2580
`define SMSC_BAUD_4800       16'h12c0
`define SMSC_BAUD_2400       16'h0960
`define SMSC_DIV_19200       (`SMSC_CLK_HZ / 19200)
`define SMSC_DIV_9600        (`SMSC_CLK_HZ / 9600)
`define SMSC_DIV_4800        (`SMSC_CLK_HZ / 4800)
`define SMSC_DIV_2400        (`SMSC_CLK_HZ / 2400)
`define SMSC_CHR_XON         8'h11
`define SMSC_CHR_XOFF        8'h13
`define SMSC_CHR_LF          8'h0a
`define SMSC_CHR_PROMPT      8'h3e
`define SMSC_ANS_ON          16'h0001
`define SMSC_ANS_OFF         16'h0000

`endif

/* rtl/smsc_pkg.sv */
// types shared by the status and serial configuration block
package smsc_pkg;

    typedef enum logic [3:0]
    {
        SMSC_CMD_NONE       = 4'h0,
        SMSC_CMD_QMASK_SET  = 4'h1,
        SMSC_CMD_QMASK_QRY  = 4'h2,
        SMSC_CMD_QEVENT_QRY = 4'h3,
        SMSC_CMD_ADDR_SET   = 4'h4,
        SMSC_CMD_ADDR_QRY   = 4'h5,
        SMSC_CMD_BAUD_SET   = 4'h6,
        SMSC_CMD_BAUD_QRY   = 4'h7,
        SMSC_CMD_ECHO_SET   = 4'h8,
        SMSC_CMD_ECHO_QRY   = 4'h9,
        SMSC_CMD_PACE_SET   = 4'ha,
        SMSC_CMD_PACE_QRY   = 4'hb,
        SMSC_CMD_PROM_SET   = 4'hc,
        SMSC_CMD_PROM_QRY   = 4'hd,
        SMSC_CMD_DEV_RESET  = 4'he
    } smsc_cmd_t;

    typedef enum logic [3:0]
    {
        SMSC_B19200 = 4'b0001,
        SMSC_B9600  = 4'b0010,
        SMSC_B4800  = 4'b0100,
        SMSC_B2400  = 4'b1000
    } smsc_baud_t;

endpackage

/* rtl/smsc_ser_echo.sv */
// serial transmit side: character echo, prompt character and xon/xoff pacing
`timescale 1ns/1ps
`include "smsc_defs.svh"

module smsc_ser_echo
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // settings
    input  wire logic       echo_on_req,
    input  wire logic       echo_off_req,
    input  wire logic       pace_en,
    input  wire logic       prompt_en,
    input  wire logic       parse_done,
    // receive side
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_char,
    // transmit side
    output logic            tx_valid,
    output logic      [7:0] tx_char,
    input  wire logic       tx_ready,
    // state
    output logic            echo_active,
    output logic            tx_paused
);

    logic       echo_reg,    echo_next;
    logic       off_pend_reg, off_pend_next;
    logic       pause_reg,   pause_next;
    logic       full_reg,    full_next;
    logic [7:0] char_reg,    char_next;
    logic       prom_reg,    prom_next;
    logic       is_pace_chr;
    logic       free;

    assign is_pace_chr = pace_en && (rx_char == `SMSC_CHR_XON || rx_char == `SMSC_CHR_XOFF);

    always_comb
    begin
        echo_next     = echo_reg;
        off_pend_next = off_pend_reg;
        pause_next    = pause_reg;
        full_next     = full_reg;
        char_next     = char_reg;
        prom_next     = prom_reg || (parse_done && prompt_en);
        if (echo_on_req)
        begin
            echo_next     = 1'b1;
            off_pend_next = 1'b0;
        end
        else if (echo_off_req && echo_reg)
            off_pend_next = 1'b1;
        // echo stops at the edge that takes the terminator, which is still echoed then if the buffer is free
        // a fresh echo-on in the same cycle wins over the pending stop
        if (rx_valid && echo_reg && off_pend_reg && rx_char == `SMSC_CHR_LF && !echo_on_req)
        begin
            echo_next     = 1'b0;
            off_pend_next = 1'b0;
        end
        if (!pace_en)
            pause_next = 1'b0;
        else if (rx_valid && rx_char == `SMSC_CHR_XOFF)
            pause_next = 1'b1;
        else if (rx_valid && rx_char == `SMSC_CHR_XON)
            pause_next = 1'b0;
        free = !full_reg || (tx_ready && !pause_reg);
        if (full_reg && tx_ready && !pause_reg)
            full_next = 1'b0;
        if (free && rx_valid && echo_reg && !is_pace_chr)
        begin
            full_next = 1'b1;
            char_next = rx_char;
        end
        else if (free && prom_reg)
        begin
            full_next = 1'b1;
            char_next = `SMSC_CHR_PROMPT;
            prom_next = parse_done && prompt_en;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            echo_reg     <= 1'b0;
            off_pend_reg <= 1'b0;
            pause_reg    <= 1'b0;
            full_reg     <= 1'b0;
            char_reg     <= 8'h00;
            prom_reg     <= 1'b0;
        end
        else
        begin
            echo_reg     <= echo_next;
            off_pend_reg <= off_pend_next;
            pause_reg    <= pause_next;
            full_reg     <= full_next;
            char_reg     <= char_next;
            prom_reg     <= prom_next;
        end
    end

    assign tx_valid    = full_reg && !pause_reg;
    assign tx_char     = char_reg;
    assign echo_active = echo_reg;
    assign tx_paused   = pause_reg;

    chk_pause_holds_tx: assert property (@(posedge core_clk) disable iff (reset)
        pause_reg |-> !tx_valid)
        else $error("transmit while paused");

    chk_echo_off_wait: assert property (@(posedge core_clk) disable iff (reset)
        (echo_reg && !(rx_valid && rx_char == `SMSC_CHR_LF) && !echo_on_req) |=> echo_reg)
        else $error("echo stopped without terminator");

    chk_echo_loaded: assert property (@(posedge core_clk) disable iff (reset)
        (rx_valid && echo_reg && !is_pace_chr && !full_reg) |=> (full_reg && char_reg == $past(rx_char)))
        else $error("received char not echoed");

endmodule

/* verif/smsc_host_model.sv */
// serial transmitter stand-in that takes characters from the block, with optional stall
`timescale 1ns/1ps

module smsc_host_model
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // transmit handshake
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_char,
    output logic            tx_ready,
    // bench control and observation
    input  wire logic       stall,
    output logic      [7:0] got_char,
    output int              got_cnt
);
    // a slow transmitter holds ready low, so a waiting character must stay put
    assign tx_ready = !stall;

    // a character is taken only at an edge where valid and ready are both high
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            got_char <= 8'h00;
            got_cnt  <= 0;
        end
        else if (tx_valid && tx_ready)
        begin
            got_char <= tx_char;
            got_cnt  <= got_cnt + 1;
        end
    end
endmodule

/* verif/smsc_cmd_tb_top.sv */
// self-checking bench for the status mask and serial settings block
`timescale 1ns/1ps
`include "smsc_defs.svh"

module smsc_cmd_tb_top;
    import smsc_pkg::*;

    logic        core_clk, reset, cmd_valid, resp_valid, cmd_reject, addr_match;
    logic        parse_done, rx_valid, tx_valid, tx_ready, tx_paused, stall;
    smsc_cmd_t   cmd_code;
    logic [15:0] cmd_arg, resp_data, ques_cond, m_ev, m_mask, s_rdata;
    logic        s_rvalid;
    logic [7:0]  status_byte_in, status_byte, rx_char, tx_char, got_char, m_last;
    logic [4:0]  bus_target_addr, bus_addr;
    logic [12:0] baud_div;
    int          got_cnt, n_fail, num_checks, m_cnt, m_addr, m_rate, a, r;
    int          addrs[4] = '{0, 30, 17, 31};
    int          rates[5] = '{19200, 2400, 4800, 9600, 1234};

    smsc_cmd u_smsc_cmd (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .resp_valid(resp_valid),
        .resp_data(resp_data), .cmd_reject(cmd_reject), .ques_cond(ques_cond),
        .status_byte_in(status_byte_in), .status_byte(status_byte),
        .bus_target_addr(bus_target_addr), .addr_match(addr_match), .bus_addr(bus_addr),
        .baud_div(baud_div), .parse_done(parse_done), .rx_valid(rx_valid),
        .rx_char(rx_char), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
        .tx_paused(tx_paused));

    smsc_host_model u_smsc_host_model (.core_clk(core_clk), .reset(reset),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .stall(stall),
        .got_char(got_char), .got_cnt(got_cnt));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // entered at a falling edge; answer is registered by the taking edge and captured
    // while it stands; one idle edge follows so valid is never dropped and raised at once
    task automatic issue(input smsc_cmd_t code, input logic [15:0] arg, input logic rej);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_arg = arg;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_arg = ~arg;
        s_rvalid = resp_valid;
        s_rdata = resp_data;
        check("cmd_reject", {15'h0000, rej}, {15'h0000, cmd_reject});
        @(negedge core_clk);
    endtask

    task automatic query(input smsc_cmd_t code, input logic [15:0] exp);
        issue(code, 16'h0000, 1'b0);
        check("resp_valid", 16'h0001, {15'h0000, s_rvalid});
        check("resp_data", exp, s_rdata);
    endtask

    task automatic settle();
        repeat (3) @(negedge core_clk);
        check("tx count", 16'(m_cnt), got_cnt[15:0]);
        check("tx char", {8'h00, m_last}, {8'h00, got_char});
    endtask

    task automatic rx(input logic [7:0] c, input bit echoed);
        rx_valid = 1'b1;
        rx_char = c;
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_char = ~c;
        if (echoed)
        begin
            m_cnt++;
            m_last = c;
        end
        settle();
    endtask

    task automatic ev_step(input logic [15:0] cond);
        ques_cond = cond;
        status_byte_in = 8'($urandom);
        @(negedge core_clk);
        m_ev = m_ev | (cond & 16'h3000);
        check("status_byte", {8'h00, status_byte_in[7:4], |(m_ev & m_mask),
            status_byte_in[2:0]}, {8'h00, status_byte});
    endtask

    initial
    begin
        repeat (6000) @(posedge core_clk);
        n_fail++;
        test_done();
    end

    initial
    begin
        reset = 1'b1;
        {cmd_valid, parse_done, rx_valid, stall} = 4'h0;
        cmd_code = SMSC_CMD_NONE;
        {cmd_arg, ques_cond, m_ev, m_mask} = 64'h0;
        {status_byte_in, rx_char, m_last} = 24'h0;
        bus_target_addr = 5'h00;
        {n_fail, num_checks, m_cnt} = 96'h0;
        void'($urandom(33954));
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        query(SMSC_CMD_ADDR_QRY, 16'd6);
        query(SMSC_CMD_BAUD_QRY, 16'd9600);
        query(SMSC_CMD_QMASK_QRY, 16'h0000);
        query(SMSC_CMD_ECHO_QRY, 16'h0000);
        query(SMSC_CMD_PACE_QRY, 16'h0000);
        query(SMSC_CMD_PROM_QRY, 16'h0000);
        issue(SMSC_CMD_NONE, 16'h0000, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            m_mask = 16'($urandom) | ((i == 0) ? 16'h3000 : 16'h0000);
            issue(SMSC_CMD_QMASK_SET, m_mask, 1'b0);
            query(SMSC_CMD_QMASK_QRY, m_mask);
            query(SMSC_CMD_QMASK_QRY, m_mask);
            ev_step(16'($urandom) | (i[0] ? 16'h1000 : 16'h2000));
            ev_step(16'h0000);
            query(SMSC_CMD_QEVENT_QRY, m_ev);
            m_ev = 16'h0000;
            ev_step(16'h0000);
        end
        addrs[2] = int'($urandom % 31);
        foreach (addrs[k])
        begin
            a = addrs[k];
            issue(SMSC_CMD_ADDR_SET, 16'(a), a > 30);
            if (a <= 30)
                m_addr = a;
            query(SMSC_CMD_ADDR_QRY, 16'(m_addr));
            check("bus_addr", 16'(m_addr), {11'h000, bus_addr});
            bus_target_addr = 5'(m_addr);
            #1 check("addr_match hit", 16'h0001, {15'h0000, addr_match});
            bus_target_addr = 5'(m_addr) ^ 5'h01;
            #1 check("addr_match miss", 16'h0000, {15'h0000, addr_match});
            @(negedge core_clk);
        end
        foreach (rates[k])
        begin
            r = rates[k];
            issue(SMSC_CMD_BAUD_SET, 16'(r), r == 1234);
            if (r != 1234)
                m_rate = r;
            query(SMSC_CMD_BAUD_QRY, 16'(m_rate));
            check("baud_div", 16'(10000000 / m_rate), {3'h0, baud_div});
        end
        rx(8'h61, 1'b0);
        issue(SMSC_CMD_ECHO_SET, 16'h0001, 1'b0);
        query(SMSC_CMD_ECHO_QRY, 16'h0001);
        rx(8'h41, 1'b1);
        issue(SMSC_CMD_DEV_RESET, 16'h0000, 1'b0);
        query(SMSC_CMD_ECHO_QRY, 16'h0001);
        stall = 1'b1;
        rx(8'h42, 1'b0);
        check("tx_valid held", 16'h0001, {15'h0000, tx_valid});
        check("tx_char held", 16'h0042, {8'h00, tx_char});
        stall = 1'b0;
        m_cnt++;
        m_last = 8'h42;
        settle();
        issue(SMSC_CMD_ECHO_SET, 16'h0000, 1'b0);
        rx(8'h43, 1'b1);
        rx(`SMSC_CHR_LF, 1'b1);
        rx(8'h44, 1'b0);
        query(SMSC_CMD_ECHO_QRY, 16'h0000);
        issue(SMSC_CMD_ECHO_SET, 16'h0002, 1'b1);
        issue(SMSC_CMD_ECHO_SET, 16'h0001, 1'b0);
        issue(SMSC_CMD_PACE_SET, 16'h0001, 1'b0);
        query(SMSC_CMD_PACE_QRY, 16'h0001);
        rx(`SMSC_CHR_XOFF, 1'b0);
        check("paused", 16'h0001, {15'h0000, tx_paused});
        rx(8'h45, 1'b0);
        check("tx_valid paused", 16'h0000, {15'h0000, tx_valid});
        m_cnt++;
        m_last = 8'h45;
        rx(`SMSC_CHR_XON, 1'b0);
        check("resumed", 16'h0000, {15'h0000, tx_paused});
        issue(SMSC_CMD_PACE_SET, 16'h0003, 1'b1);
        issue(SMSC_CMD_PACE_SET, 16'h0000, 1'b0);
        query(SMSC_CMD_PACE_QRY, 16'h0000);
        rx(`SMSC_CHR_XOFF, 1'b1);
        check("not paused", 16'h0000, {15'h0000, tx_paused});
        for (int p = 1; p >= 0; p--)
        begin
            issue(SMSC_CMD_PROM_SET, 16'(p), 1'b0);
            query(SMSC_CMD_PROM_QRY, 16'(p));
            parse_done = 1'b1;
            @(negedge core_clk);
            parse_done = 1'b0;
            if (p == 1)
            begin
                m_cnt++;
                m_last = `SMSC_CHR_PROMPT;
            end
            settle();
        end
        test_done();
    end
endmodule
